// ===== src/gpio_pin_irq.sv
// port pin interrupt detection, masking, clear and pin function select
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_irq
    import gpio_irq_pkg::*;
#(
    parameter port_id_type PORT_ID = PORT_A_SEL
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [PIN_COUNT-1:0] pin_in,
    output logic      [PIN_COUNT-1:0] pin_irq,
    output logic                      port_combined_interrupt,
    output logic                      converter_trigger,
    output pin_ctrl_type              pin_ctrl
);

    localparam logic [7:0] RST_FSEL = (PORT_ID == PORT_B_SEL) ? RST_FSEL_PORT_B :
                                      (PORT_ID == PORT_C_SEL) ? RST_FSEL_PORT_C : RST_FSEL_OTHER;
    localparam bit HAS_CONV_TRIG = (PORT_ID == PORT_B_SEL);

    irq_cfg_type          cfg_r;
    logic [7:0]           direction_r;
    logic [7:0]           func_sel_r;
    logic [7:0]           raw_r;
    logic [7:0]           raw_nxt;
    logic [7:0]           masked;
    logic [7:0]           pin_s;
    logic [7:0]           pin_prev_r;
    logic [7:0]           rise;
    logic [7:0]           fall;
    logic [7:0]           edge_hit;
    logic [7:0]           level_hit;
    logic [7:0]           clear_bits;
    logic [31:0]          prdata_r;
    logic                 pslverr_r;
    logic                 wr_acc;
    logic                 setup;
    logic                 addr_hit;
    logic [7:0]           rd_byte;

    pin_sync u_pin_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .pin_async    (pin_in),
        .pin_sync_out (pin_s)
    );

    // previous synchronised sample for edge compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_r <= RST_ZERO;
        end else if (ce) begin
            pin_prev_r <= pin_s;
        end
    end

    assign rise = pin_s & ~pin_prev_r;
    assign fall = ~pin_s & pin_prev_r;

    // per-pin trigger qualification
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_detect
        always_comb begin
            if (cfg_r.dual_edge_bits[i]) begin
                edge_hit[i] = rise[i] | fall[i];
            end else begin
                edge_hit[i] = cfg_r.polarity_bits[i] ? rise[i] : fall[i];
            end
            level_hit[i] = cfg_r.polarity_bits[i] ? pin_s[i] : ~pin_s[i];
        end
    end

    // apb decode: zero wait states while enabled, ce low stalls the access
    assign pready   = ce;
    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite & ce;
    assign clear_bits = (wr_acc && paddr == OFF_CLEAR) ? pwdata[7:0] : RST_ZERO;

    // edge pins latch until cleared, a fresh edge beats a clear in the same cycle
    always_comb begin
        for (int j = 0; j < PIN_COUNT; j++) begin
            if (cfg_r.sense_bits[j]) begin
                raw_nxt[j] = level_hit[j];
            end else begin
                raw_nxt[j] = edge_hit[j] | (raw_r[j] & ~clear_bits[j]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_r <= RST_ZERO;
        end else if (ce) begin
            raw_r <= raw_nxt;
        end
    end

    assign masked                  = raw_r & cfg_r.unmask_bits;
    assign pin_irq                 = masked;
    assign port_combined_interrupt = |masked;
    // raw pin 4 condition: the converter only gets it while the pin is unmasked
    assign converter_trigger       = HAS_CONV_TRIG & masked[CONV_TRIG_PIN];

    // interrupt configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= RST_IRQ_CFG;
        end else if (wr_acc) begin
            unique case (paddr)
                OFF_SENSE:     cfg_r.sense_bits     <= pwdata[7:0];
                OFF_DUAL_EDGE: cfg_r.dual_edge_bits <= pwdata[7:0];
                OFF_POLARITY:  cfg_r.polarity_bits  <= pwdata[7:0];
                OFF_MASK:      cfg_r.unmask_bits    <= pwdata[7:0];
                default:       cfg_r <= cfg_r;
            endcase
        end
    end

    // pin ownership and direction; both resets land here through presetn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_r <= RST_ZERO;
            func_sel_r  <= RST_FSEL;
        end else if (wr_acc) begin
            if (paddr == OFF_DIRECTION) begin
                direction_r <= pwdata[7:0];
            end
            if (paddr == OFF_FUNC_SEL) begin
                func_sel_r <= pwdata[7:0];
            end
        end
    end

    assign pin_ctrl.pin_direction_select     = direction_r;
    assign pin_ctrl.peripheral_takeover_bits = func_sel_r;

    // read mux; clear register reads zero since it is write-only
    always_comb begin
        addr_hit = 1'b1;
        rd_byte  = RST_ZERO;
        unique case (paddr)
            OFF_DIRECTION: rd_byte = direction_r;
            OFF_SENSE:     rd_byte = cfg_r.sense_bits;
            OFF_DUAL_EDGE: rd_byte = cfg_r.dual_edge_bits;
            OFF_POLARITY:  rd_byte = cfg_r.polarity_bits;
            OFF_MASK:      rd_byte = cfg_r.unmask_bits;
            OFF_RAW:       rd_byte = raw_r;
            OFF_MASKED:    rd_byte = masked;
            OFF_CLEAR:     rd_byte = RST_ZERO;
            OFF_FUNC_SEL:  rd_byte = func_sel_r;
            default:       addr_hit = 1'b0;
        endcase
    end

    // read data captured in the setup cycle, reserved bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce && setup) begin
            prdata_r  <= {24'h00_0000, pwrite ? RST_ZERO : rd_byte};
            pslverr_r <= ~addr_hit;
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = pslverr_r & psel & penable;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence edge_seen_s(logic [7:0] hit);
        ce && (hit != 8'h00);
    endsequence

    level_follow_a: assert property (ce |=> ((raw_r & $past(cfg_r.sense_bits)) ==
            ($past(level_hit) & $past(cfg_r.sense_bits))))
        else $error("level pin raw status does not follow qualified level");

    dual_edge_a: assert property (edge_seen_s(rise | fall) |=>
            ((($past(rise | fall) & $past(~cfg_r.sense_bits & cfg_r.dual_edge_bits)) & ~raw_r) == 8'h00))
        else $error("dual-edge pin missed a transition");

    rise_single_a: assert property (edge_seen_s(rise) |=>
            ((($past(rise) & $past(~cfg_r.sense_bits & ~cfg_r.dual_edge_bits & cfg_r.polarity_bits))
            & ~raw_r) == 8'h00))
        else $error("rising edge not latched");

    fall_single_a: assert property (edge_seen_s(fall) |=>
            ((($past(fall) & $past(~cfg_r.sense_bits & ~cfg_r.dual_edge_bits & ~cfg_r.polarity_bits))
            & ~raw_r) == 8'h00))
        else $error("falling edge not latched");

    no_spurious_a: assert property (ce |=>
            ((raw_r & ~$past(raw_r) & ~$past(edge_hit) & ~$past(cfg_r.sense_bits)) == 8'h00))
        else $error("edge pin raw status set without an edge");

    mask_gate_a: assert property ((cfg_r.unmask_bits == 8'h00) |->
            (!port_combined_interrupt && pin_irq == 8'h00))
        else $error("masked pins raised an interrupt");

    irq_follows_a: assert property (ce ##1 (masked != 8'h00) |-> port_combined_interrupt)
        else $error("unmasked condition did not reach combined interrupt");

    clear_edge_a: assert property ((wr_acc && paddr == OFF_CLEAR) |=>
            ((raw_r & $past(pwdata[7:0] & ~cfg_r.sense_bits & ~edge_hit)) == 8'h00))
        else $error("edge status survived a clear");

    conv_trig_a: assert property (HAS_CONV_TRIG && raw_r[CONV_TRIG_PIN]
            && cfg_r.unmask_bits[CONV_TRIG_PIN] |-> converter_trigger && port_combined_interrupt)
        else $error("converter trigger missing on unmasked pin 4");

    fsel_write_a: assert property ((wr_acc && paddr == OFF_FUNC_SEL) |=>
            pin_ctrl.peripheral_takeover_bits == $past(pwdata[7:0]))
        else $error("function select write not applied");

    // bus and reset steps shared by the read-back and reset checks
    sequence apb_setup_s;
        ce && psel && !penable;
    endsequence

    sequence apb_access_s;
        psel && penable && pready;
    endsequence

    sequence reset_held_s;
        !presetn ##1 !presetn;
    endsequence

    // the default disable would hide the reset state, so these two stay live through reset
    reset_values_a: assert property (disable iff (1'b0) reset_held_s |->
            (raw_r == RST_ZERO && cfg_r == RST_IRQ_CFG && func_sel_r == RST_FSEL && direction_r == RST_ZERO))
        else $error("registers not at their reset values");

    reset_outputs_a: assert property (disable iff (1'b0) reset_held_s |->
            (pin_irq == RST_ZERO && !port_combined_interrupt && !converter_trigger && prdata == 32'h0000_0000))
        else $error("outputs not quiet during reset");

    rd_raw_a: assert property ((apb_setup_s ##0 (!pwrite && paddr == OFF_RAW)) |=>
            (prdata[7:0] == $past(raw_r)))
        else $error("raw status read-back wrong");

    rd_masked_a: assert property ((apb_setup_s ##0 (!pwrite && paddr == OFF_MASKED)) |=>
            (prdata[7:0] == $past(raw_r & cfg_r.unmask_bits)))
        else $error("masked status read-back wrong");

    rd_clear_a: assert property ((apb_setup_s ##0 (!pwrite && paddr == OFF_CLEAR)) |=>
            (prdata == 32'h0000_0000))
        else $error("clear register did not read zero");

    rd_upper_a: assert property (prdata[31:8] == 24'h00_0000)
        else $error("reserved read bits not zero");

    prdata_hold_a: assert property (!(ce && setup) |=> $stable(prdata))
        else $error("read data moved outside a setup cycle");

    err_phase_a: assert property ((apb_setup_s ##1 apb_access_s) |-> (pslverr == !$past(addr_hit)))
        else $error("error response does not match the decode");

    err_idle_a: assert property (!(psel && penable) |-> !pslverr)
        else $error("error response outside an access phase");

    ready_stall_a: assert property (!ce |-> !pready)
        else $error("ready high while clock enable is low");

    // a stall must neither lose nor invent an edge, so the edge history freezes too
    ce_freeze_a: assert property (!ce |=> ($stable(raw_r) && $stable(cfg_r) && $stable(pin_prev_r)
            && $stable(direction_r) && $stable(func_sel_r) && $stable(prdata_r)))
        else $error("state moved while clock enable was low");

    ro_write_a: assert property ((wr_acc && (paddr == OFF_RAW || paddr == OFF_MASKED)) |=>
            ($stable(cfg_r) && $stable(direction_r) && $stable(func_sel_r)))
        else $error("write to a status register changed configuration");

    unmapped_write_a: assert property ((wr_acc && !addr_hit) |=>
            ($stable(cfg_r) && $stable(direction_r) && $stable(func_sel_r)))
        else $error("write to an unmapped address changed configuration");

    mask_write_a: assert property ((wr_acc && paddr == OFF_MASK) |=>
            (cfg_r.unmask_bits == $past(pwdata[7:0])))
        else $error("mask write not applied");

    sense_write_a: assert property ((wr_acc && paddr == OFF_SENSE) |=>
            (cfg_r.sense_bits == $past(pwdata[7:0])))
        else $error("sense write not applied");

    dir_write_a: assert property ((wr_acc && paddr == OFF_DIRECTION) |=>
            (pin_ctrl.pin_direction_select == $past(pwdata[7:0])))
        else $error("direction write not applied");

    edge_sticky_a: assert property ((ce && !(wr_acc && paddr == OFF_CLEAR)) |=>
            ((($past(raw_r) & ~$past(cfg_r.sense_bits)) & ~raw_r) == 8'h00))
        else $error("edge status dropped without a clear");

    clear_zero_a: assert property ((wr_acc && paddr == OFF_CLEAR) |=>
            ((($past(raw_r) & ~$past(cfg_r.sense_bits) & ~$past(pwdata[7:0])) & ~raw_r) == 8'h00))
        else $error("clear write with zero bit dropped a status");

    pin_mask_a: assert property ((pin_irq & ~cfg_r.unmask_bits) == 8'h00)
        else $error("masked pin drives its own interrupt");

    combined_or_a: assert property (port_combined_interrupt == (pin_irq != 8'h00))
        else $error("combined interrupt disagrees with pin interrupts");

    // other ports have no converter path at all
    trig_cause_a: assert property (converter_trigger |->
            (HAS_CONV_TRIG && raw_r[CONV_TRIG_PIN] && cfg_r.unmask_bits[CONV_TRIG_PIN]))
        else $error("converter trigger without an unmasked pin 4 condition");

    fsel_hold_a: assert property (!(wr_acc && paddr == OFF_FUNC_SEL) |=> $stable(func_sel_r))
        else $error("function select changed without a write");

endmodule // gpio_pin_irq

`default_nettype wire

// ===== src/gpio_irq_pkg.sv
// shared constants and types for the port interrupt and function select block
package gpio_irq_pkg;

    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ADDR_W    = 12;

    // register byte offsets
    localparam logic [11:0] OFF_DIRECTION  = 12'h400;
    localparam logic [11:0] OFF_SENSE      = 12'h404;
    localparam logic [11:0] OFF_DUAL_EDGE  = 12'h408;
    localparam logic [11:0] OFF_POLARITY   = 12'h40c;
    localparam logic [11:0] OFF_MASK       = 12'h410;
    localparam logic [11:0] OFF_RAW        = 12'h414;
    localparam logic [11:0] OFF_MASKED     = 12'h418;
    localparam logic [11:0] OFF_CLEAR      = 12'h41c;
    localparam logic [11:0] OFF_FUNC_SEL   = 12'h420;

    // values after reset
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_FSEL_PORT_B = 8'h80;
    localparam logic [7:0] RST_FSEL_PORT_C = 8'h0f;
    localparam logic [7:0] RST_FSEL_OTHER  = 8'h00;

    // pin that also drives the converter trigger on port b
    localparam int unsigned CONV_TRIG_PIN  = 4;

    // synchroniser depth in flip-flops
    localparam int unsigned SYNC_STAGES    = 2;

    typedef enum logic [2:0] {
        PORT_A_SEL,
        PORT_B_SEL,
        PORT_C_SEL,
        PORT_D_SEL,
        PORT_E_SEL
    } port_id_type;

    // per-pin interrupt configuration, one byte per field
    typedef struct packed {
        logic [7:0] sense_bits;
        logic [7:0] dual_edge_bits;
        logic [7:0] polarity_bits;
        logic [7:0] unmask_bits;
    } irq_cfg_type;

    localparam irq_cfg_type RST_IRQ_CFG = '{default: 8'h00};

    // pin configuration handed to the pad and peripheral muxes
    typedef struct packed {
        logic [7:0] pin_direction_select;
        logic [7:0] peripheral_takeover_bits;
    } pin_ctrl_type;

endpackage

// ===== src/pin_sync.sv
// two-flop synchroniser for the eight port input pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync
    import gpio_irq_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    input  wire logic [PIN_COUNT-1:0] pin_async,
    output logic      [PIN_COUNT-1:0] pin_sync_out
);

    logic [PIN_COUNT-1:0] meta_r;
    logic [PIN_COUNT-1:0] sync_r;

    // meta_r is read only by sync_r
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RST_ZERO;
            sync_r <= RST_ZERO;
        end else if (ce) begin
            meta_r <= pin_async;
            sync_r <= meta_r;
        end
    end

    assign pin_sync_out = sync_r;

endmodule // pin_sync

`default_nettype wire

// ===== test/pin_driver_model.sv
// far-side model: eight external pins that change off the bus clock phase
`timescale 1ns/1ps
`default_nettype none

module pin_driver_model (
    input  wire logic       pclk,
    input  wire logic [7:0] want,
    input  wire logic [4:0] lag,
    output logic      [7:0] pin_level
);
    // pins start low so reset release shows no rising edge
    initial pin_level = 8'h00;

    // lag delays each change by 0 to 31 ns, within the 40 ns clock period
    always @(posedge pclk) begin
        pin_level <= #(lag) want;
    end
endmodule // pin_driver_model

`default_nettype wire

// ===== test/gpio_pin_irq_tb.sv
// self-checking bench for the port pin interrupt and function select block
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_irq_tb
    import gpio_irq_pkg::*;
;
    logic         pclk = 0;
    logic         presetn = 0;
    logic         ce = 1;
    logic         psel = 0;
    logic         penable = 0;
    logic         pwrite = 0;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [31:0]  prdata;
    logic [31:0]  rd;
    logic         pready;
    logic         pslverr;
    logic         er;
    logic         port_combined_interrupt;
    logic         converter_trigger;
    logic [7:0]   pin_irq;
    logic [7:0]   pins;
    logic [7:0]   want = 0;
    logic [7:0]   old, sense, dual, pol, mask, raw, clr;
    logic [4:0]   lag = 0;
    pin_ctrl_type pin_ctrl;
    pin_ctrl_type ctrl_c;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cyc = 0;

    always #20 pclk = ~pclk;

    gpio_pin_irq #(.PORT_ID(PORT_B_SEL)) gpio_pin_irq_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pins), .pin_irq(pin_irq), .port_combined_interrupt(port_combined_interrupt),
        .converter_trigger(converter_trigger), .pin_ctrl(pin_ctrl));

    // port c copy only shows its reset pin setup, so it is never selected
    gpio_pin_irq #(.PORT_ID(PORT_C_SEL)) gpio_pin_irq_c_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(1'b0), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .pin_in(pins), .pin_irq(),
        .port_combined_interrupt(), .converter_trigger(), .pin_ctrl(ctrl_c));

    pin_driver_model pin_driver_model_inst (.pclk(pclk), .want(want), .lag(lag), .pin_level(pins));

    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // entered right after a rising edge; st stalls the access phase by dropping ce
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input int st = 0);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        if (st > 0) begin
            ce <= 0;
            repeat (st) @(posedge pclk);
            chk("pready stalled", pready, 0);
            ce <= 1;
        end
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input int st = 0);
        apb(1, a, d, st);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 8'h00);
        chk(nm, rd, exp);
    endtask

    task automatic defaults();
        for (int i = 0; i < 9; i++) begin
            rdc("reset value", OFF_DIRECTION + 12'(4 * i), (i == 8) ? 32'h80 : 32'h0);
            chk("mapped error", er, 0);
        end
        chk("ctrl b", {16'h0, pin_ctrl}, 32'h0080);
        chk("ctrl c", {16'h0, ctrl_c}, 32'h000f);
    endtask

    function automatic logic [7:0] nxt(input logic [7:0] r, input logic [7:0] p, input logic [7:0] q);
        logic [7:0] rise, fall, hit;
        rise = ~p & q;
        fall = p & ~q;
        hit = (dual & (rise | fall)) | (~dual & pol & rise) | (~dual & ~pol & fall);
        return (~sense & (r | hit)) | (sense & ~(pol ^ q));
    endfunction

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'hea9fb39e));
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        defaults();
        wr(12'h424, 8'hff);
        chk("unmapped write error", er, 1);
        rdc("unmapped data", 12'h424, 0);
        chk("unmapped error", er, 1);
        // debug-shared pin 7 stays with its peripheral
        wr(OFF_FUNC_SEL, 8'hda, 2);
        rdc("fsel", OFF_FUNC_SEL, 32'hda);
        chk("takeover", pin_ctrl.peripheral_takeover_bits, 8'hda);
        wr(OFF_DIRECTION, 8'h3c);
        chk("direction", pin_ctrl.pin_direction_select, 8'h3c);
        for (int n = 0; n < 40; n++) begin
            {sense, dual, pol, mask} = $urandom;
            // first passes force pure edge modes, single and dual
            if (n < 4) begin
                sense = 8'h00;
                dual = (n % 2) ? 8'hff : 8'h00;
            end
            wr(OFF_SENSE, sense);
            wr(OFF_DUAL_EDGE, dual);
            wr(OFF_POLARITY, pol);
            wr(OFF_MASK, mask, n % 3);
            rdc("mask", OFF_MASK, mask);
            wr(OFF_CLEAR, 8'hff);
            raw = sense & ~(pol ^ pins);
            rdc("raw after clear", OFF_RAW, raw);
            wr(OFF_RAW, 8'hff);
            old = pins;
            want <= 8'($urandom);
            lag <= 5'($urandom);
            repeat (8) @(posedge pclk);
            raw = nxt(raw, old, want);
            rdc("raw", OFF_RAW, raw);
            rdc("masked", OFF_MASKED, raw & mask);
            chk("pin irq", pin_irq, raw & mask);
            chk("combined", port_combined_interrupt, |(raw & mask));
            chk("trigger", converter_trigger, raw[4] & mask[4]);
            clr = 8'($urandom);
            wr(OFF_CLEAR, clr);
            rdc("clear read", OFF_CLEAR, 0);
            rdc("raw cleared", OFF_RAW, (raw & ~clr) | (raw & sense));
        end
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        defaults();
        end_of_test();
    end
endmodule // gpio_pin_irq_tb

`default_nettype wire
